// [common/ctr_pkg.sv]
package ctr_pkg;
    localparam int          REG_W            = 16;
    localparam int          ADDR_W           = 8;
    localparam int          NCH              = 3;
    localparam logic [7:0]  GEN_TRIG_ADDR    = 8'h20;
    localparam logic [7:0]  CH_TRIG_ADDR     = 8'h21;
    localparam logic [7:0]  STATUS_ADDR      = 8'h23;
    localparam logic [15:0] TRIG_RESET_VAL   = 16'h0000;
    localparam int          UNLOCK_MSB       = 15;
    localparam int          UNLOCK_LSB       = 12;
    localparam logic [3:0]  UNLOCK_PATTERN   = 4'h5;
    localparam int          SOFT_RST_MSB     = 11;
    localparam int          SOFT_RST_LSB     = 8;
    localparam logic [3:0]  SOFT_RST_PATTERN = 4'hA;
    localparam int          LOAD_BIT         = 7;
    localparam int          CLEAR_BIT        = 6;
    localparam int          DUMP_BIT         = 4;
    localparam int          PROTECT_BIT      = 3;
    localparam int          ROW_READ_BIT     = 2;
    localparam int          PROG_BIT         = 1;
    localparam int          RELOAD_BIT       = 0;
    localparam int          CMP_CLEAR_BIT    = 3;
    localparam int          PROTECT_FLAG_BIT = 8;
    // per-channel bit positions, channel 0..2
    localparam int          RUN_POS [NCH]    = '{4, 0, 12};
    localparam int          HI_POS  [NCH]    = '{5, 1, 13};
    localparam int          LO_POS  [NCH]    = '{6, 2, 14};
    localparam logic [15:0] GEN_RD_MASK      = 16'hF000;
    localparam logic [15:0] CH_RD_MASK       = 16'h1011;
endpackage

// [design/ctr_pulse.sv]
`timescale 1ns/10ps
module ctr_pulse
    import ctr_pkg::*;
#(
    parameter int W = 8
) (
    // clocking
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         clk_en,
    // request and pulse
    input  wire logic [W-1:0] fire,
    output logic      [W-1:0] pulse
);
    typedef struct packed {
        logic [W-1:0] pulse;
    } ctr_pulse_st_t;

    ctr_pulse_st_t st_q;
    ctr_pulse_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            st_d.pulse = fire;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse = st_q.pulse;

    a_pulse_single : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !fire[0]) |=> !pulse[0])
        else $error("pulse lasted past its request");
endmodule

// [design/ctr_run_ctl.sv]
`timescale 1ns/10ps
module ctr_run_ctl
    import ctr_pkg::*;
#(
    parameter int N = NCH
) (
    // clocking
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         clk_en,
    // register write
    input  wire logic         wr,
    input  wire logic [N-1:0] wr_val,
    // run levels
    output logic      [N-1:0] waveform_run
);
    typedef struct packed {
        logic [N-1:0] run;
    } ctr_run_st_t;

    ctr_run_st_t st_q;
    ctr_run_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (clk_en && wr) begin
            st_d.run = wr_val;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign waveform_run = st_q.run;

    a_run_hold : assert property (@(posedge ref_clk) disable iff (!resetn)
        !(clk_en && wr) |=> $stable(waveform_run))
        else $error("run level changed without write");
endmodule

// [design/ctr_trigger_regs.sv]
`timescale 1ns/10ps
module ctr_trigger_regs
    import ctr_pkg::*;
(
    // clocking
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    // register port from serial interface
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [REG_W-1:0]  reg_wdata,
    output logic      [REG_W-1:0]  reg_rdata,
    // general actions
    output logic                   unlock_key,
    output logic                   soft_reset,
    output logic                   load_outputs_trigger,
    output logic                   clear_outputs_trigger,
    output logic                   fault_dump_trigger,
    output logic                   protect_trigger,
    output logic                   single_row_read_trigger,
    output logic                   store_program_trigger,
    output logic                   store_reload_trigger,
    // per-channel actions, run levels and the single comparator latch clear
    input  wire logic [NCH-1:0]    sync_enable,
    input  wire logic [NCH-1:0]    clear_value_select,
    output logic      [NCH-1:0]    load_channel,
    output logic      [NCH-1:0]    clear_channel,
    output logic      [NCH-1:0]    clear_to_mid,
    output logic      [NCH-1:0]    margin_low_trigger,
    output logic      [NCH-1:0]    margin_high_trigger,
    output logic      [NCH-1:0]    waveform_run,
    output logic                   comparator_latch_clear,
    // protect status
    output logic                   protect_flag
);
    localparam int NP = 9 + 2 * NCH + 1;

    typedef struct packed {
        logic [REG_W-1:0] rdata;
        logic             protect_flag;
        logic [NCH-1:0]   clr_mid;
    } ctr_main_st_t;

    ctr_main_st_t st_q;
    ctr_main_st_t st_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
        hit = (a == target);
    endfunction

    logic            wr_gen;
    logic            wr_ch;
    logic [NP-1:0]   fire;
    logic [NP-1:0]   pulses;
    logic [NCH-1:0]  lo_bits;
    logic [NCH-1:0]  hi_bits;
    logic [NCH-1:0]  run_bits;
    logic            status_read;

    assign wr_gen      = reg_wr && hit(reg_addr, GEN_TRIG_ADDR);
    assign wr_ch       = reg_wr && hit(reg_addr, CH_TRIG_ADDR);
    assign status_read = reg_rd && hit(reg_addr, STATUS_ADDR);

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            assign lo_bits[gi]  = reg_wdata[LO_POS[gi]];
            assign hi_bits[gi]  = reg_wdata[HI_POS[gi]];
            assign run_bits[gi] = reg_wdata[RUN_POS[gi]];
        end
    endgenerate

    // one request bit per action; writing 0 requests nothing
    always_comb begin
        fire     = '0;
        fire[0]  = wr_gen && (reg_wdata[UNLOCK_MSB:UNLOCK_LSB] == UNLOCK_PATTERN);
        fire[1]  = wr_gen && (reg_wdata[SOFT_RST_MSB:SOFT_RST_LSB] == SOFT_RST_PATTERN);
        fire[2]  = wr_gen && reg_wdata[LOAD_BIT];
        fire[3]  = wr_gen && reg_wdata[CLEAR_BIT];
        fire[4]  = wr_gen && reg_wdata[DUMP_BIT];
        fire[5]  = wr_gen && reg_wdata[PROTECT_BIT];
        fire[6]  = wr_gen && reg_wdata[ROW_READ_BIT];
        fire[7]  = wr_gen && reg_wdata[PROG_BIT];
        fire[8]  = wr_gen && reg_wdata[RELOAD_BIT];
        fire[9 +: NCH]       = wr_ch ? lo_bits : '0;
        fire[9 + NCH +: NCH] = wr_ch ? hi_bits : '0;
        fire[NP-1] = wr_ch && reg_wdata[CMP_CLEAR_BIT];
    end

    ctr_pulse #(
        .W (NP)
    ) u_pulse (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .fire    (fire),
        .pulse   (pulses)
    );

    ctr_run_ctl #(
        .N (NCH)
    ) u_run (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .clk_en       (clk_en),
        .wr           (wr_ch),
        .wr_val       (run_bits),
        .waveform_run (waveform_run)
    );

    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            if (fire[3]) begin
                st_d.clr_mid = clear_value_select;
            end
            // a new protect launch beats the clearing read
            if (fire[5]) begin
                st_d.protect_flag = 1'b1;
            end else if (status_read) begin
                st_d.protect_flag = 1'b0;
            end
            st_d.rdata = '0;
            if (reg_rd) begin
                if (hit(reg_addr, GEN_TRIG_ADDR)) begin
                    // key is not kept; every bit reads 0
                    st_d.rdata = '0;
                end else if (hit(reg_addr, CH_TRIG_ADDR)) begin
                    st_d.rdata = '0;
                    for (int i = 0; i < NCH; i++) begin
                        st_d.rdata[RUN_POS[i]] = waveform_run[i];
                    end
                end else if (hit(reg_addr, STATUS_ADDR)) begin
                    st_d.rdata[PROTECT_FLAG_BIT] = st_q.protect_flag;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata               = st_q.rdata;
    assign protect_flag            = st_q.protect_flag;
    assign unlock_key              = pulses[0];
    assign soft_reset              = pulses[1];
    assign load_outputs_trigger    = pulses[2];
    assign clear_outputs_trigger   = pulses[3];
    assign fault_dump_trigger      = pulses[4];
    assign protect_trigger         = pulses[5];
    assign single_row_read_trigger = pulses[6];
    assign store_program_trigger   = pulses[7];
    assign store_reload_trigger    = pulses[8];
    assign margin_low_trigger      = pulses[9 +: NCH];
    assign margin_high_trigger     = pulses[9 + NCH +: NCH];
    assign comparator_latch_clear  = pulses[NP-1];
    assign load_channel            = {NCH{pulses[2]}} & sync_enable;
    assign clear_channel           = {NCH{pulses[3]}};
    assign clear_to_mid            = st_q.clr_mid;

    a_unlock_key : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[15:12] == 4'h5) |=> unlock_key)
        else $error("unlock key not presented");
    a_unlock_wrong : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[15:12] == 4'h5)) |=> !unlock_key)
        else $error("unlock without key");
    a_soft_reset : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[11:8] == 4'hA) |=>
            soft_reset ##1 (!soft_reset || $past(fire[1]) || !$past(clk_en)))
        else $error("soft reset pulse wrong");
    a_reset_wrong : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[11:8] == 4'hA)) |=> !soft_reset)
        else $error("soft reset without pattern");
    a_load_sync : assert property (@(posedge ref_clk) disable iff (!resetn)
        load_channel != '0 |-> load_outputs_trigger && (load_channel & ~sync_enable) == '0)
        else $error("load on unsynced channel");
    a_load_chan : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[7]) |=> load_channel == sync_enable)
        else $error("load missed a synced channel");
    a_load_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[7])) |=> !load_outputs_trigger)
        else $error("load without request");
    a_clear_fire : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[6]) |=> clear_outputs_trigger)
        else $error("clear not fired");
    a_clear_level : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[6]) |=> clear_to_mid == $past(clear_value_select))
        else $error("clear level not captured");
    a_clear_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[6])) |=> !clear_outputs_trigger)
        else $error("clear without request");
    a_dump_fire : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[4]) |=> fault_dump_trigger)
        else $error("fault dump not fired");
    a_dump_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[4])) |=> !fault_dump_trigger)
        else $error("fault dump without request");
    a_protect_fire : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[3]) |=> protect_trigger && protect_flag)
        else $error("protect not fired or flagged");
    a_protect_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[3])) |=> !protect_trigger)
        else $error("protect without request");
    a_row_fire : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[2]) |=> single_row_read_trigger)
        else $error("row read not fired");
    a_row_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[2])) |=> !single_row_read_trigger)
        else $error("row read without request");
    a_prog_fire : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[1]) |=> store_program_trigger)
        else $error("program not fired");
    a_prog_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[1])) |=> !store_program_trigger)
        else $error("program without request");
    a_reload_fire : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata[0]) |=> store_reload_trigger)
        else $error("reload not fired");
    a_reload_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_gen && reg_wdata[0])) |=> !store_reload_trigger)
        else $error("reload without request");
    a_margin_lo : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_ch && reg_wdata[14]) |=> margin_low_trigger[2])
        else $error("margin low ch2 not fired");
    a_margin_lo0 : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_ch && reg_wdata[6]) |=> margin_low_trigger[0])
        else $error("margin low ch0 not fired");
    a_margin_lo1 : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_ch && reg_wdata[2]) |=> margin_low_trigger[1])
        else $error("margin low ch1 not fired");
    a_margin_lo_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !wr_ch) |=> margin_low_trigger == '0)
        else $error("margin low without write");
    a_margin_hi : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_ch && reg_wdata[1]) |=> margin_high_trigger[1])
        else $error("margin high ch1 not fired");
    a_margin_hi0 : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_ch && reg_wdata[5]) |=> margin_high_trigger[0])
        else $error("margin high ch0 not fired");
    a_margin_hi2 : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_ch && reg_wdata[13]) |=> margin_high_trigger[2])
        else $error("margin high ch2 not fired");
    a_margin_hi_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !wr_ch) |=> margin_high_trigger == '0)
        else $error("margin high without write");
    a_run_write : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_ch) |=> waveform_run == {$past(reg_wdata[12]), $past(reg_wdata[0]), $past(reg_wdata[4])})
        else $error("run bits not taken");
    a_ch_read_run : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && reg_rd && hit(reg_addr, 8'h21)) |=>
            reg_rdata[12] == $past(waveform_run[2]) && reg_rdata[4] == $past(waveform_run[0])
            && reg_rdata[0] == $past(waveform_run[1]))
        else $error("run bits not read back");
    a_cmp_clear : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_ch && reg_wdata[3]) |=> comparator_latch_clear)
        else $error("comparator clear not fired");
    a_cmp_idle : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !(wr_ch && reg_wdata[3])) |=> !comparator_latch_clear)
        else $error("comparator clear without request");
    a_flag_read : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && status_read && !fire[5]) |=> !protect_flag ##0 reg_rdata[8] == $past(protect_flag))
        else $error("protect flag read clear wrong");
    a_flag_hold : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && !status_read && !fire[5]) |=> $stable(protect_flag))
        else $error("protect flag changed unprompted");
    a_gen_read0 : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && reg_rd && hit(reg_addr, 8'h20)) |=> reg_rdata == 16'h0000)
        else $error("trigger readback not zero");
    a_ch_dontcare : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && reg_rd && hit(reg_addr, 8'h21)) |=> (reg_rdata & 16'hEFEE) == 16'h0000)
        else $error("don't-care bits not zero");
    a_status_dontcare : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && status_read) |=> (reg_rdata & 16'hFEFF) == 16'h0000)
        else $error("status spare bits not zero");
    a_other_read : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && reg_rd && !hit(reg_addr, 8'h20) && !hit(reg_addr, 8'h21) && !hit(reg_addr, 8'h23)) |=>
            reg_rdata == 16'h0000)
        else $error("undecoded read not zero");
    a_bit5_ignored : assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && wr_gen && reg_wdata == 16'h0020) |=> !(unlock_key || soft_reset || load_outputs_trigger
            || clear_outputs_trigger || fault_dump_trigger || protect_trigger || single_row_read_trigger
            || store_program_trigger || store_reload_trigger))
        else $error("don't-care bit fired an action");
endmodule

// [verification/ctr_host_model.sv]
`timescale 1ns/10ps
module ctr_host_model
    import ctr_pkg::*;
(
    // clocking
    input  wire logic         ref_clk,
    // register port toward the block
    output logic              reg_wr,
    output logic              reg_rd,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [REG_W-1:0]  reg_wdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
    end
    // one strobe cycle; strobes then drop and address and data show the inverse so stale values never pass
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(negedge ref_clk);
        reg_wr    = wr;
        reg_rd    = ~wr;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // key first, then lock bit cleared in the configuration register
    task automatic unlock();
        access(1'b1, 8'h20, 16'h5000);
        access(1'b1, 8'h1F, 16'h0000);
    endtask
endmodule

// [verification/ctr_trigger_regs_bench.sv]
`timescale 1ns/10ps
module ctr_trigger_regs_bench;
    import ctr_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [15:0] d;
        logic [8:0]  g;
        logic [6:0]  c;
    } ctr_row_t;
    logic              ref_clk, resetn, clk_en, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [REG_W-1:0]  reg_wdata, reg_rdata, last21;
    logic              unlock_key, soft_reset, load_outputs_trigger, clear_outputs_trigger, fault_dump_trigger;
    logic              protect_trigger, single_row_read_trigger, store_program_trigger, store_reload_trigger;
    logic [NCH-1:0]    sync_enable, clear_value_select, load_channel, clear_channel, clear_to_mid;
    logic [NCH-1:0]    margin_low_trigger, margin_high_trigger, waveform_run;
    logic              comparator_latch_clear, protect_flag;
    logic [8:0]        gen;
    logic [12:0]       chv;
    int                error_cnt, num_checks, unl_cnt;
    ctr_row_t          rows [20] = '{
        '{8'h20, 16'h5000, 9'h100, 7'h00}, '{8'h20, 16'h4000, 9'h000, 7'h00}, '{8'h20, 16'h0A00, 9'h080, 7'h00},
        '{8'h20, 16'h0B00, 9'h000, 7'h00}, '{8'h20, 16'h0080, 9'h040, 7'h00}, '{8'h20, 16'h0040, 9'h020, 7'h00},
        '{8'h20, 16'h0010, 9'h010, 7'h00}, '{8'h20, 16'h0008, 9'h008, 7'h00}, '{8'h20, 16'h0004, 9'h004, 7'h00},
        '{8'h20, 16'h0002, 9'h002, 7'h00}, '{8'h20, 16'h0001, 9'h001, 7'h00}, '{8'h20, 16'h0020, 9'h000, 7'h00},
        '{8'h21, 16'h5000, 9'h000, 7'h40}, '{8'h21, 16'h0045, 9'h000, 7'h30}, '{8'h21, 16'h2010, 9'h000, 7'h08},
        '{8'h21, 16'h0022, 9'h000, 7'h06}, '{8'h21, 16'h8F88, 9'h000, 7'h01}, '{8'h22, 16'hFFFF, 9'h000, 7'h00},
        '{8'h21, 16'hFFFF, 9'h000, 7'h7F}, '{8'h20, 16'hFFFF, 9'h07F, 7'h00}};
    assign gen = {unlock_key, soft_reset, load_outputs_trigger, clear_outputs_trigger, fault_dump_trigger,
                  protect_trigger, single_row_read_trigger, store_program_trigger, store_reload_trigger};
    assign chv = {load_channel, clear_channel, margin_low_trigger, margin_high_trigger, comparator_latch_clear};
    ctr_host_model i_ctr_host_model (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    ctr_trigger_regs i_ctr_trigger_regs (
        .ref_clk, .resetn, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .unlock_key, .soft_reset, .load_outputs_trigger, .clear_outputs_trigger, .fault_dump_trigger,
        .protect_trigger, .single_row_read_trigger, .store_program_trigger, .store_reload_trigger,
        .sync_enable, .clear_value_select, .load_channel, .clear_channel, .clear_to_mid,
        .margin_low_trigger, .margin_high_trigger, .waveform_run, .comparator_latch_clear, .protect_flag);
    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (unlock_key === 1'b1) unl_cnt++;
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        i_ctr_host_model.access(1'b0, a, 16'h0000);
        chk("read data", {16'h0, exp}, {16'h0, reg_rdata});
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        results();
    end
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        sync_enable = 3'b101;
        clear_value_select = 3'b010;
        last21 = 16'h0000;
        repeat (5) @(negedge ref_clk);
        resetn = 1'b1;
        rd(8'h20, 16'h0000);
        rd(8'h21, 16'h0000);
        foreach (rows[i]) begin
            i_ctr_host_model.access(1'b1, rows[i].a, rows[i].d);
            if (rows[i].a == 8'h21) last21 = rows[i].d & 16'h1011;
            chk("actions", {23'h0, rows[i].g}, {23'h0, gen});
            chk("channel actions", {19'h0, rows[i].g[6] ? 3'b101 : 3'b000, rows[i].g[5] ? 3'b111 : 3'b000,
                rows[i].c}, {19'h0, chv});
            if (rows[i].g[5]) chk("clear level", {29'h0, 3'b010}, {29'h0, clear_to_mid});
            chk("run", {29'h0, last21[12], last21[0], last21[4]}, {29'h0, waveform_run});
            @(negedge ref_clk);
            chk("pulse end", 32'h0, {10'h0, gen, chv});
            rd(8'h21, last21);
        end
        rd(8'h20, 16'h0000);
        chk("protect flag", 32'h1, {31'h0, protect_flag});
        rd(8'h23, 16'h0100);
        chk("protect flag", 32'h0, {31'h0, protect_flag});
        rd(8'h23, 16'h0000);
        clk_en = 1'b0;
        i_ctr_host_model.access(1'b1, 8'h20, 16'h0080);
        chk("frozen", 32'h0, {23'h0, gen});
        clk_en = 1'b1;
        sync_enable = 3'b010;
        clear_value_select = 3'b101;
        i_ctr_host_model.access(1'b1, 8'h20, 16'h00C8);
        chk("load channels", 32'h2, {29'h0, load_channel});
        chk("clear level", 32'h5, {29'h0, clear_to_mid});
        clear_value_select = 3'b000;
        @(negedge ref_clk);
        chk("clear level held", 32'h5, {29'h0, clear_to_mid});
        chk("protect flag", 32'h1, {31'h0, protect_flag});
        unl_cnt = 0;
        i_ctr_host_model.unlock();
        chk("unlock count", 32'h1, unl_cnt);
        resetn = 1'b0;
        #5;
        chk("reset run", 32'h0, {29'h0, waveform_run});
        chk("reset flag", 32'h0, {31'h0, protect_flag});
        @(negedge ref_clk);
        resetn = 1'b1;
        rd(8'h21, 16'h0000);
        rd(8'h23, 16'h0000);
        results();
    end
endmodule
